// *** shared/msk_exec_map.vh ***
// Purpose: offsets, fields, codes and reset values of the subtract/skip/table unit
// Assumes: AHB-Lite word registers, byte addresses
// Notes: included by hw/msk_exec.v
// Function
// - borrow-subtract from memory: work minus operand minus inverted carry into work.
// - after any subtraction carry is 0 for negative, 1 for positive or zero.
// - every subtraction updates overflow, zero, half-carry, carry, signed and chained flags.
// - immediate borrow-subtract takes immediate and inverted carry from work, into work.
// - borrow-subtract to memory writes memory and keeps the working register.
// - plain subtract ignores carry; result to work, or to memory for memory form.
// - decrement-and-skip writes byte minus one back, skips when it is zero.
// - increment-and-skip writes byte plus one back, skips when it is zero.
// - work forms of those put the value in work, keep memory, skip on zero.
// - a taken skip costs a second, dummy cycle while the next word is fetched.
// - set-byte writes ff to the byte and leaves all flags alone.
// - set-bit forces only the chosen bit to one, flags untouched.
// - skip-if-nonzero, byte and bit forms, skips when the tested value is not 0.
// - skip-if-zero byte skips on a zero byte, memory and flags unchanged.
// - copy-and-test loads the byte into work and skips when it is zero.
// - skip-if-bit-clear skips when the chosen bit of the byte is 0.
// - nibble exchange swaps bits 3..0 with 7..4 of the byte, flags unchanged.
// - work form of nibble exchange writes work and keeps the memory byte.
// - table fetch reads word at both pointers; low byte to memory, high to latch.
// - last-page fetch uses the top program page and the low pointer only.
// - pre-increment fetch bumps the low pointer first, then fetches as normal.
// - pre-increment last-page fetch bumps low pointer first, flags untouched.
`ifndef MSK_EXEC_MAP_VH
`define MSK_EXEC_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define MSK_OFS_CMD    12'h000
`define MSK_OFS_STAT   12'h004
`define MSK_OFS_WORK   12'h008
`define MSK_OFS_FLAGS  12'h00c
`define MSK_OFS_TPLO   12'h010
`define MSK_OFS_TPHI   12'h014
`define MSK_OFS_THL    12'h018
`define MSK_DMEM_BASE  2'h1
// ****************************************
// command word fields
// ****************************************
`define MSK_CMD_OP     4:0
`define MSK_CMD_BIT    7:5
`define MSK_CMD_ADDR   15:8
`define MSK_CMD_IMM    23:16
// ****************************************
// flag bit positions
// ****************************************
`define MSK_FL_C   0
`define MSK_FL_AC  1
`define MSK_FL_Z   2
`define MSK_FL_OV  3
`define MSK_FL_SC  4
`define MSK_FL_CZ  5
`define MSK_FLAGS_RST  6'h00
`define MSK_BYTE_RST   8'h00
`define MSK_BYTE_ONES  8'hff
// ****************************************
// operation codes
// ****************************************
`define MSK_OP_SUB_M     5'h00
`define MSK_OP_SUB_I     5'h01
`define MSK_OP_SUB_TOM   5'h02
`define MSK_OP_SBC_M     5'h03
`define MSK_OP_SBC_I     5'h04
`define MSK_OP_SBC_TOM   5'h05
`define MSK_OP_DEC_SKIP  5'h06
`define MSK_OP_DEC_SKIPW 5'h07
`define MSK_OP_INC_SKIP  5'h08
`define MSK_OP_INC_SKIPW 5'h09
`define MSK_OP_SNZ_BYTE  5'h0a
`define MSK_OP_SNZ_BIT   5'h0b
`define MSK_OP_SZ_BYTE   5'h0c
`define MSK_OP_SZ_BIT    5'h0d
`define MSK_OP_COPY_SKIP 5'h0e
`define MSK_OP_SET_BYTE  5'h0f
`define MSK_OP_SET_BIT   5'h10
`define MSK_OP_SWAP      5'h11
`define MSK_OP_SWAPW     5'h12
`define MSK_OP_TBL       5'h13
`define MSK_OP_TBL_LAST  5'h14
`define MSK_OP_TBL_INC   5'h15
`define MSK_OP_TBL_INCL  5'h16
`endif

// *** hw/msk_exec.v ***
// Purpose: execution of subtract, skip, set, swap and table-fetch operations
// Assumes: AHB-Lite slave, synchronous program memory with one cycle read latency
// Notes: bus transfers stall while an operation runs
//        reads take one wait state, writes none
//        program word is taken the cycle after its strobe
//        data memory is not reset
`timescale 1ns/1ps
`include "msk_exec_map.vh"
module msk_exec #(
   parameter PM_AW = 13,
   parameter DM_AW = 8
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   output reg  [PM_AW-1:0] pmAddr,
   output reg         pmRen,
   input  wire [15:0] pmRdData,
   output reg         skipPulse,
   output reg         opDone
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_FETCH = 3'd1;
   localparam ST_TWAIT = 3'd2;
   localparam ST_EXEC  = 3'd3;
   localparam ST_DUMMY = 3'd4;

   // ****************************************
   // helpers
   // ****************************************
   function isNull;
      input [7:0] v;
      begin
         isNull = (v == 8'h00);
      end
   endfunction

   function [7:0] nibSwap;
      input [7:0] v;
      begin
         nibSwap = {v[3:0], v[7:4]};
      end
   endfunction

   // bus byte address to array index
   function [DM_AW-1:0] dmIndex;
      input [11:0] ad;
      begin
         dmIndex = ad[DM_AW+1:2];
      end
   endfunction

   // {ov, ac, c, result}
   function [10:0] subFlags;
      input [7:0] a;
      input [7:0] b;
      input       bin;
      reg   [8:0] full;
      reg   [4:0] low;
      begin
         full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
         low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
         subFlags = {(a[7] != b[7]) && (full[7] != a[7]), ~low[4], ~full[8], full[7:0]};
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg [7:0]  dmem [0:(1<<DM_AW)-1];
   reg [2:0]  state_reg;
   reg [23:0] cmd_reg;
   reg [7:0]  work_reg;
   reg [5:0]  flags_reg;
   reg [7:0]  tpLo_reg;
   reg [7:0]  tpHi_reg;
   reg [7:0]  thl_reg;
   reg [7:0]  opnd_reg;
   reg        lastSkip_reg;
   reg        dpValid_reg;
   reg        dpWrite_reg;
   reg [11:0] dpAddr_reg;
   reg        rdDone_reg;

   // ****************************************
   // operation decode
   // ****************************************
   wire [4:0]  op = cmd_reg[`MSK_CMD_OP];
   wire [2:0]  bitSel = cmd_reg[`MSK_CMD_BIT];
   wire [7:0]  mAddr = cmd_reg[`MSK_CMD_ADDR];
   wire [7:0]  imm = cmd_reg[`MSK_CMD_IMM];
   wire        busy = (state_reg != ST_IDLE);
   wire        isTbl = (op == `MSK_OP_TBL) || (op == `MSK_OP_TBL_LAST) ||
                       (op == `MSK_OP_TBL_INC) || (op == `MSK_OP_TBL_INCL);
   wire        isPre = (op == `MSK_OP_TBL_INC) || (op == `MSK_OP_TBL_INCL);
   wire        isLast = (op == `MSK_OP_TBL_LAST) || (op == `MSK_OP_TBL_INCL);
   wire [7:0]  tpLoUse = isPre ? tpLo_reg + 8'h01 : tpLo_reg;
   wire [15:0] fullPtr = {tpHi_reg, tpLoUse};

   // ****************************************
   // bus slave
   // ****************************************
   wire accept = hsel & htrans[1] & hready;
   wire dpFree = ~busy & (dpWrite_reg | rdDone_reg);
   wire busWr = dpValid_reg & dpWrite_reg & ~busy & ce;
   wire isDmem = (dpAddr_reg[11:10] == `MSK_DMEM_BASE);
   wire [7:0] wrByte = hwdata[7:0];

   // a pending transfer stalls while the enable is low
   assign hreadyout = ce & (~dpValid_reg | dpFree);
   assign hresp = 1'b0;

   // read mux is registered into hrdata: one wait state
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      if (isDmem) begin
         rdMux = {24'h000000, dmem[dmIndex(dpAddr_reg)]};
      end else begin
         case (dpAddr_reg)
            `MSK_OFS_CMD:   rdMux = {8'h00, cmd_reg};
            `MSK_OFS_STAT:  rdMux = {30'h00000000, lastSkip_reg, busy};
            `MSK_OFS_WORK:  rdMux = {24'h000000, work_reg};
            `MSK_OFS_FLAGS: rdMux = {26'h0000000, flags_reg};
            `MSK_OFS_TPLO:  rdMux = {24'h000000, tpLo_reg};
            `MSK_OFS_TPHI:  rdMux = {24'h000000, tpHi_reg};
            `MSK_OFS_THL:   rdMux = {24'h000000, thl_reg};
            default:        rdMux = 32'h00000000;
         endcase
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dpValid_reg <= 1'b0;
         dpWrite_reg <= 1'b0;
         dpAddr_reg <= 12'h000;
         rdDone_reg <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (ce) begin
         if (hreadyout) begin
            dpValid_reg <= accept;
            dpWrite_reg <= hwrite;
            dpAddr_reg <= {haddr[11:2], 2'b00};
            rdDone_reg <= 1'b0;
         end else if (dpValid_reg & ~dpWrite_reg & ~busy) begin
            rdDone_reg <= 1'b1;
            hrdata <= rdMux;
         end
      end
   end

   // ****************************************
   // execution
   // ****************************************
   reg        memWe;
   reg [7:0]  memWd;
   reg [7:0]  workNext;
   reg [5:0]  flagsNext;
   reg        skipNext;
   reg [10:0] sr;
   reg [7:0]  inc;
   reg [7:0]  dec;

   always @* begin
      memWe = 1'b0;
      memWd = opnd_reg;
      workNext = work_reg;
      flagsNext = flags_reg;
      skipNext = 1'b0;
      inc = opnd_reg + 8'h01;
      dec = opnd_reg - 8'h01;
      sr = 11'h000;
      case (op)
         `MSK_OP_SUB_M, `MSK_OP_SUB_TOM:
            sr = subFlags(work_reg, opnd_reg, 1'b0);
         `MSK_OP_SUB_I:
            sr = subFlags(work_reg, imm, 1'b0);
         `MSK_OP_SBC_M, `MSK_OP_SBC_TOM:
            sr = subFlags(work_reg, opnd_reg, ~flags_reg[`MSK_FL_C]);
         `MSK_OP_SBC_I:
            sr = subFlags(work_reg, imm, ~flags_reg[`MSK_FL_C]);
         default:
            sr = 11'h000;
      endcase
      case (op)
         `MSK_OP_SUB_M, `MSK_OP_SUB_I, `MSK_OP_SUB_TOM,
         `MSK_OP_SBC_M, `MSK_OP_SBC_I, `MSK_OP_SBC_TOM: begin
            if ((op == `MSK_OP_SUB_TOM) || (op == `MSK_OP_SBC_TOM)) begin
               memWe = 1'b1;
               memWd = sr[7:0];
            end else begin
               workNext = sr[7:0];
            end
            flagsNext[`MSK_FL_C] = sr[8];
            flagsNext[`MSK_FL_AC] = sr[9];
            flagsNext[`MSK_FL_OV] = sr[10];
            flagsNext[`MSK_FL_Z] = isNull(sr[7:0]);
            flagsNext[`MSK_FL_SC] = sr[10] ^ sr[7];
            if ((op == `MSK_OP_SBC_M) || (op == `MSK_OP_SBC_I) || (op == `MSK_OP_SBC_TOM))
               flagsNext[`MSK_FL_CZ] = isNull(sr[7:0]) & flags_reg[`MSK_FL_Z];
            else
               flagsNext[`MSK_FL_CZ] = isNull(sr[7:0]);
         end
         `MSK_OP_DEC_SKIP: begin
            memWe = 1'b1;
            memWd = dec;
            skipNext = isNull(dec);
         end
         `MSK_OP_DEC_SKIPW: begin
            workNext = dec;
            skipNext = isNull(dec);
         end
         `MSK_OP_INC_SKIP: begin
            memWe = 1'b1;
            memWd = inc;
            skipNext = isNull(inc);
         end
         `MSK_OP_INC_SKIPW: begin
            workNext = inc;
            skipNext = isNull(inc);
         end
         `MSK_OP_SNZ_BYTE: begin
            skipNext = ~isNull(opnd_reg);
         end
         `MSK_OP_SNZ_BIT: begin
            skipNext = opnd_reg[bitSel];
         end
         `MSK_OP_SZ_BYTE: begin
            skipNext = isNull(opnd_reg);
         end
         `MSK_OP_SZ_BIT: begin
            skipNext = ~opnd_reg[bitSel];
         end
         `MSK_OP_COPY_SKIP: begin
            workNext = opnd_reg;
            skipNext = isNull(opnd_reg);
         end
         `MSK_OP_SET_BYTE: begin
            memWe = 1'b1;
            memWd = `MSK_BYTE_ONES;
         end
         `MSK_OP_SET_BIT: begin
            memWe = 1'b1;
            memWd = opnd_reg | (8'h01 << bitSel);
         end
         `MSK_OP_SWAP: begin
            memWe = 1'b1;
            memWd = nibSwap(opnd_reg);
         end
         `MSK_OP_SWAPW: begin
            workNext = nibSwap(opnd_reg);
         end
         `MSK_OP_TBL, `MSK_OP_TBL_LAST, `MSK_OP_TBL_INC, `MSK_OP_TBL_INCL: begin
            memWe = 1'b1;
            memWd = pmRdData[7:0];
         end
         default: begin
            memWe = 1'b0;
         end
      endcase
   end

   // ****************************************
   // data memory
   // ****************************************
   wire exWe = ce & (state_reg == ST_EXEC) & memWe;
   // one write port: bus writes happen only while idle
   always @(posedge ref_clk) begin
      if (exWe)
         dmem[mAddr[DM_AW-1:0]] <= memWd;
      else if (busWr & isDmem)
         dmem[dmIndex(dpAddr_reg)] <= wrByte;
   end

   // ****************************************
   // sequencer
   // ****************************************
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cmd_reg <= 24'h000000;
         work_reg <= `MSK_BYTE_RST;
         flags_reg <= `MSK_FLAGS_RST;
         tpLo_reg <= `MSK_BYTE_RST;
         tpHi_reg <= `MSK_BYTE_RST;
         thl_reg <= `MSK_BYTE_RST;
         opnd_reg <= `MSK_BYTE_RST;
         lastSkip_reg <= 1'b0;
         pmAddr <= {PM_AW{1'b0}};
         pmRen <= 1'b0;
         skipPulse <= 1'b0;
         opDone <= 1'b0;
      end else if (ce) begin
         pmRen <= 1'b0;
         skipPulse <= 1'b0;
         opDone <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // register and command writes land only while idle
               if (busWr & ~isDmem) begin
                  case (dpAddr_reg)
                     `MSK_OFS_CMD: begin
                        cmd_reg <= hwdata[23:0];
                        state_reg <= ST_FETCH;
                     end
                     `MSK_OFS_WORK: begin
                        work_reg <= wrByte;
                     end
                     `MSK_OFS_FLAGS: begin
                        flags_reg <= hwdata[5:0];
                     end
                     `MSK_OFS_TPLO: begin
                        tpLo_reg <= wrByte;
                     end
                     `MSK_OFS_TPHI: begin
                        tpHi_reg <= wrByte;
                     end
                     default: begin
                        state_reg <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_FETCH: begin
               opnd_reg <= dmem[mAddr[DM_AW-1:0]];
               if (isTbl) begin
                  tpLo_reg <= tpLoUse;
                  // strobe leaves with the address, word is back in exec
                  pmRen <= 1'b1;
                  if (isLast)
                     pmAddr <= {{(PM_AW-8){1'b1}}, tpLoUse};
                  else
                     pmAddr <= fullPtr[PM_AW-1:0];
                  state_reg <= ST_TWAIT;
               end else begin
                  state_reg <= ST_EXEC;
               end
            end
            ST_TWAIT: begin
               state_reg <= ST_EXEC;
            end
            ST_EXEC: begin
               work_reg <= workNext;
               flags_reg <= flagsNext;
               if (isTbl)
                  thl_reg <= pmRdData[15:8];
               lastSkip_reg <= skipNext;
               if (skipNext) begin
                  state_reg <= ST_DUMMY;
               end else begin
                  opDone <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_DUMMY: begin
               // stands for the fetch of the skipped word
               skipPulse <= 1'b1;
               opDone <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** testbench/msk_exec_sva.sv ***
// Purpose: port assertions for the subtract/skip/table unit
// Assumes: hready is looped back from hreadyout, one slave
// Notes: bind statement follows the module
`timescale 1ns/1ps
`include "msk_exec_map.vh"
module msk_exec_sva #(
   parameter PM_AW = 13
) (
   input logic             ref_clk,
   input logic             rst_n,
   input logic             hsel,
   input logic [31:0]      haddr,
   input logic [1:0]       htrans,
   input logic             hwrite,
   input logic [31:0]      hwdata,
   input logic             hready,
   input logic             hreadyout,
   input logic             hresp,
   input logic [PM_AW-1:0] pmAddr,
   input logic             pmRen,
   input logic             skipPulse,
   input logic             opDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence cmdWr;
      hsel && htrans[1] && hready && hwrite && haddr[11:0] == `MSK_OFS_CMD;
   endsequence
   sequence rdTaken;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence waitThenReady;
      !hreadyout ##[1:6] hreadyout;
   endsequence
   cmd_done_a: assert property (cmdWr |-> ##[4:5] opDone)
      else $error("operation did not finish in time");
   skip_pair_a: assert property (skipPulse |-> opDone && !$past(opDone))
      else $error("skip pulse without finishing dummy cycle");
   done_pulse_a: assert property (opDone |=> !opDone)
      else $error("done pulse too long");
   op_idle_a: assert property (opDone && !hreadyout |=> hreadyout)
      else $error("bus still stalled at done");
   pm_pulse_a: assert property (pmRen |=> !pmRen)
      else $error("program read strobe too long");
   pm_hold_a: assert property (pmRen |=> $stable(pmAddr))
      else $error("program address moved under strobe");
   pm_done_a: assert property (pmRen |-> ##2 opDone)
      else $error("table fetch did not finish");
   last_page_a: assert property (cmdWr ##1 (hwdata[4:0] == `MSK_OP_TBL_LAST)
      |-> ##2 (pmRen && &pmAddr[PM_AW-1:8]))
      else $error("last page fetch off the top page");
   set_noskip_a: assert property (cmdWr ##1 (hwdata[4:0] == `MSK_OP_SET_BYTE)
      |-> ##3 (opDone && !skipPulse))
      else $error("set byte timing wrong");
   rd_wait_a: assert property (rdTaken |=> waitThenReady)
      else $error("read wait state missing");
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("error response seen");
endmodule
bind msk_exec msk_exec_sva #(.PM_AW(PM_AW)) chk (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .pmAddr(pmAddr), .pmRen(pmRen),
   .skipPulse(skipPulse), .opDone(opDone));

// *** testbench/msk_prog_mem.sv ***
// Purpose: synchronous program memory model, one cycle read latency
// Assumes: word content is a fixed function of its address
// Notes: output toggles when no read is pending
`timescale 1ns/1ps
module msk_prog_mem #(
   parameter PM_AW = 13
) (
   input  logic             ref_clk,
   input  logic [PM_AW-1:0] pmAddr,
   input  logic             pmRen,
   output logic [15:0]      pmRdData
);
   initial pmRdData = 16'h5a5a;
   always @(posedge ref_clk) begin
      if (pmRen) begin
         pmRdData <= {3'b101, pmAddr[PM_AW-1:8], pmAddr[7:0] ^ 8'h3c};
      end else begin
         pmRdData <= ~pmRdData;
      end
   end
endmodule

// *** testbench/msk_exec_tb.sv ***
// Purpose: register-level tests of the subtract/skip/table unit
// Assumes: bus reads stall until the running operation ends
// Notes: expected values worked out locally
`timescale 1ns/1ps
`include "msk_exec_map.vh"
module msk_exec_tb;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout, hresp, pmRen, skipPulse, opDone;
   logic [31:0] hrdata, rd;
   logic [12:0] pmAddr, pa;
   logic [15:0] pmRdData, w;
   logic [13:0] e;
   logic [43:0] t;
   logic [7:0]  a, b, tp;
   integer      miscompares = 0, nTests = 0, nDone = 0, nSkip = 0, eSkip = 0, i, o;
   logic [23:0] vec [4] = '{24'h10_20_01, 24'h80_01_04, 24'h35_35_04, 24'h35_34_00};
   logic [43:0] skt [21] = '{44'h1_06_00_01_00_99, 44'h0_06_00_00_ff_99, 44'h1_07_00_01_01_00,
      44'h1_08_00_ff_00_99, 44'h0_09_00_7f_7f_80, 44'h0_0a_00_00_00_99, 44'h1_0a_00_04_04_99,
      44'h1_0b_02_04_04_99, 44'h0_0b_03_04_04_99, 44'h1_0c_00_00_00_99, 44'h0_0c_00_01_01_99,
      44'h1_0d_00_fe_fe_99, 44'h0_0d_01_fe_fe_99, 44'h1_0e_00_00_00_00, 44'h0_0e_00_5a_5a_5a,
      44'h0_0f_00_12_ff_99, 44'h0_10_03_00_08_99, 44'h0_10_03_f7_ff_99, 44'h0_11_00_3c_c3_99,
      44'h0_12_00_3c_3c_c3, 44'h0_1f_00_3c_3c_99};
   always #2.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      nDone <= nDone + opDone;
      nSkip <= nSkip + skipPulse;
   end
   msk_exec uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pmAddr(pmAddr), .pmRen(pmRen),
      .pmRdData(pmRdData), .skipPulse(skipPulse), .opDone(opDone));
   msk_prog_mem pm (.ref_clk(ref_clk), .pmAddr(pmAddr), .pmRen(pmRen), .pmRdData(pmRdData));
   // ****************************************
   // bus tasks and checks
   // ****************************************
   task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      htrans <= 2'b10;
      haddr <= {20'h0, ad};
      hwrite <= wr;
      do @(negedge ref_clk); while (hreadyout !== 1'b1);
      @(posedge ref_clk);
      htrans <= 2'b00;
      hwdata <= d;
      do @(negedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      @(posedge ref_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      nTests++;
      if (got !== ex) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic rchk(input string nm, input logic [11:0] ad, input logic [31:0] ex);
      xfer(1'b0, ad, 32'h0);
      chk(nm, ex, rd);
   endtask
   function automatic logic [11:0] dm(input logic [7:0] ix);
      dm = {`MSK_DMEM_BASE, ix, 2'b00};
   endfunction
   function automatic logic [13:0] subx(input logic [7:0] x, y, input logic [5:0] f, input bit c);
      logic bin;
      logic [8:0] r;
      logic [4:0] lo;
      logic z, ov;
      bin = c & ~f[`MSK_FL_C];
      r = {1'b0, x} - y - bin;
      lo = {1'b0, x[3:0]} - y[3:0] - bin;
      z = (r[7:0] == 8'h00);
      ov = (x[7] != y[7]) && (r[7] != x[7]);
      subx = {c ? z & f[`MSK_FL_Z] : z, ov ^ r[7], ov, z, ~lo[4], ~r[8], r[7:0]};
   endfunction
   task automatic finishTest;
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      finishTest();
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rchk("flags", `MSK_OFS_FLAGS, 32'h0);
      rchk("latch", `MSK_OFS_THL, 32'h0);
      xfer(1'b1, `MSK_OFS_THL, 32'h55);
      xfer(1'b1, 12'h020, 32'h77);
      rchk("latch ro", `MSK_OFS_THL, 32'h0);
      rchk("unmapped", 12'h020, 32'h0);
      xfer(1'b1, `MSK_OFS_WORK, 32'hffff_ffa5);
      rchk("work", `MSK_OFS_WORK, 32'ha5);
      $display("test registers done");
      for (o = 0; o < 6; o++) begin
         for (i = 0; i < 4; i++) begin
            {a, b, t[7:0]} = vec[i];
            e = subx(a, b, t[5:0], o >= 3);
            xfer(1'b1, `MSK_OFS_WORK, {24'h0, a});
            xfer(1'b1, `MSK_OFS_FLAGS, {26'h0, t[5:0]});
            xfer(1'b1, dm(8'h07), {24'h0, b ^ ((o == 1 || o == 4) ? 8'hff : 8'h00)});
            xfer(1'b1, `MSK_OFS_CMD, {8'h0, b, 8'h07, 3'h0, o[4:0]});
            rchk("work", `MSK_OFS_WORK, {24'h0, (o == 2 || o == 5) ? a : e[7:0]});
            if (o == 2 || o == 5) rchk("mem", dm(8'h07), {24'h0, e[7:0]});
            rchk("flags", `MSK_OFS_FLAGS, {26'h0, e[13:8]});
         end
      end
      $display("test subtract done");
      for (i = 0; i < 21; i++) begin
         t = skt[i];
         eSkip += t[40];
         xfer(1'b1, `MSK_OFS_WORK, 32'h99);
         xfer(1'b1, `MSK_OFS_FLAGS, 32'h2a);
         xfer(1'b1, dm(8'h09), {24'h0, t[23:16]});
         xfer(1'b1, `MSK_OFS_CMD, {16'h0, 8'h09, t[26:24], t[36:32]});
         rchk("status", `MSK_OFS_STAT, {30'h0, t[40], 1'b0});
         rchk("mem", dm(8'h09), {24'h0, t[15:8]});
         rchk("work", `MSK_OFS_WORK, {24'h0, t[7:0]});
         rchk("flags", `MSK_OFS_FLAGS, 32'h2a);
         chk("skips", eSkip, nSkip);
      end
      $display("test skip done");
      tp = 8'hff;
      xfer(1'b1, `MSK_OFS_TPLO, {24'h0, tp});
      xfer(1'b1, `MSK_OFS_TPHI, 32'h12);
      for (o = 19; o < 23; o++) begin
         if (o >= 21) tp = tp + 8'h01;
         pa = (o == 20 || o == 22) ? {5'h1f, tp} : {5'h12, tp};
         w = {3'b101, pa[12:8], pa[7:0] ^ 8'h3c};
         xfer(1'b1, `MSK_OFS_CMD, {16'h0, 8'h03, 3'h0, o[4:0]});
         rchk("mem", dm(8'h03), {24'h0, w[7:0]});
         rchk("latch", `MSK_OFS_THL, {24'h0, w[15:8]});
         rchk("pointer", `MSK_OFS_TPLO, {24'h0, tp});
         rchk("flags", `MSK_OFS_FLAGS, 32'h2a);
      end
      chk("done count", 49, nDone);
      $display("test table done");
      finishTest();
   end
endmodule
